// *** shared/bpsl_defines.svh ***
// constants of the bridge parity status logic
`ifndef BPSL_DEFINES_SVH
`define BPSL_DEFINES_SVH

// register byte offsets
`define BPSL_OFF_STATUS 8'h00
`define BPSL_OFF_MASK   8'h04
`define BPSL_OFF_CTRL   8'h08

// status and mask bit positions
`define BPSL_B_PRI_DET  0
`define BPSL_B_SEC_DET  1
`define BPSL_B_PRI_DPD  2
`define BPSL_B_SEC_DPD  3

// control bit positions
`define BPSL_B_PRI_PER  0
`define BPSL_B_SEC_PER  1

// reset values
`define BPSL_RST_STATUS 4'h0
`define BPSL_RST_MASK   4'h0
`define BPSL_RST_CTRL   2'h0

// encodings of direction and bus
`define BPSL_DIR_DOWN   1'b0
`define BPSL_DIR_UP     1'b1
`define BPSL_BUS_PRI    1'b0
`define BPSL_BUS_SEC    1'b1

`endif

// *** shared/bpsl_pkg.sv ***
// types of the bridge parity status logic
package bpsl_pkg;

  // transaction kind, gray coded
  typedef enum logic [1:0] {
    BPSL_READ = 2'h0,
    BPSL_PW   = 2'h1,
    BPSL_DW   = 2'h3
  } bpsl_kind_t;

  // whole register state of the top module
  typedef struct packed {
    logic [3:0]  status;
    logic [3:0]  mask;
    logic [1:0]  ctrl;
    logic [31:0] rdata;
    logic        slverr;
  } bpsl_state_t;

endpackage

// *** shared/bpsl_evt_if.sv ***
// event carrier between top and classifier
`timescale 1ns/1ps
interface bpsl_evt_if;
  logic       valid;
  logic [1:0] kind;
  logic       dir;
  logic       bus;
  logic       bad_par;
  logic       perr_seen;
  logic       pri_master;
  logic       sec_master;
  logic       per_pri;
  logic       per_sec;
  logic [3:0] set;

  modport src (output valid, kind, dir, bus, bad_par, perr_seen,
               output pri_master, sec_master, per_pri, per_sec, input set);
  modport cls (input valid, kind, dir, bus, bad_par, perr_seen,
               input pri_master, sec_master, per_pri, per_sec, output set);
endinterface

// *** design/bpsl_classify.sv ***
// decodes one parity event into status set pulses
`timescale 1ns/1ps
`include "bpsl_defines.svh"
module bpsl_classify (
  // event in, set pulses out
  bpsl_evt_if.cls ev
);

  // kind is one of the two write kinds
  function automatic logic is_write(input logic [1:0] k);
    is_write = (k == bpsl_pkg::BPSL_PW) || (k == bpsl_pkg::BPSL_DW);
  endfunction

  // kind is a legal code
  function automatic logic is_legal(input logic [1:0] k);
    is_legal = (k == bpsl_pkg::BPSL_READ) || is_write(k);
  endfunction

  logic on_pri;
  logic on_sec;
  logic up;
  logic down;

  // ----------------------------------------------------------------
  // set decode
  // ----------------------------------------------------------------
  assign on_pri = ev.valid && is_legal(ev.kind) && (ev.bus == `BPSL_BUS_PRI);
  assign on_sec = ev.valid && is_legal(ev.kind) && (ev.bus == `BPSL_BUS_SEC);
  assign up     = (ev.dir == `BPSL_DIR_UP);
  assign down   = (ev.dir == `BPSL_DIR_DOWN);

  // upstream read or downstream write, own detection
  assign ev.set[`BPSL_B_PRI_DET] = on_pri && ev.bad_par &&
      ((ev.kind == bpsl_pkg::BPSL_READ) ? up : down);
  // downstream read or upstream write, own detection
  assign ev.set[`BPSL_B_SEC_DET] = on_sec && ev.bad_par &&
      ((ev.kind == bpsl_pkg::BPSL_READ) ? down : up);
  assign ev.set[`BPSL_B_PRI_DPD] = on_pri && up && ev.pri_master &&
      ev.per_pri && (ev.bad_par || ev.perr_seen);
  assign ev.set[`BPSL_B_SEC_DPD] = on_sec && down && ev.sec_master &&
      ev.per_sec && (ev.bad_par || ev.perr_seen);

endmodule

// *** design/bpsl_top.sv ***
// parity status bits of a bridge with apb registers and interrupt
`timescale 1ns/1ps
`include "bpsl_defines.svh"

module bpsl_top #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input  wire logic              CLK,
  input  wire logic              RST_N,
  // apb slave
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [ADDR_W-1:0] PADDR,
  input  wire logic [31:0]       PWDATA,
  output      logic [31:0]       PRDATA,
  output      logic              PREADY,
  output      logic              PSLVERR,
  // parity event from the bridge datapath
  input  wire logic              EVT_VALID,
  input  wire logic [1:0]        EVT_KIND,
  input  wire logic              EVT_DIR,
  input  wire logic              EVT_BUS,
  input  wire logic              EVT_BAD_PARITY,
  // bus pins and bus roles
  input  wire logic              PRIMARY_PARITY_ERR_N,
  input  wire logic              SECONDARY_PARITY_ERR_N,
  input  wire logic              PRI_MASTER,
  input  wire logic              SEC_MASTER,
  // status view and interrupt
  output      logic [3:0]        STATUS,
  output      logic              IRQ
);

  // register offset matches address
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
    hit = (a == ADDR_W'(off));
  endfunction

  bpsl_pkg::bpsl_state_t st;
  bpsl_pkg::bpsl_state_t next_st;
  bpsl_evt_if            ev ();
  logic                  wr_acc;
  logic                  setup;
  logic                  mapped;
  logic [3:0]            w1c;

  // ----------------------------------------------------------------
  // event classifier
  // ----------------------------------------------------------------
  // drive the carrier; the pin of the event's bus is the sampled report
  assign ev.valid      = EVT_VALID;
  assign ev.kind       = EVT_KIND;
  assign ev.dir        = EVT_DIR;
  assign ev.bus        = EVT_BUS;
  assign ev.bad_par    = EVT_BAD_PARITY;
  assign ev.perr_seen  = (EVT_BUS == `BPSL_BUS_PRI) ? !PRIMARY_PARITY_ERR_N
                                                    : !SECONDARY_PARITY_ERR_N;
  assign ev.pri_master = PRI_MASTER;
  assign ev.sec_master = SEC_MASTER;
  assign ev.per_pri    = st.ctrl[`BPSL_B_PRI_PER];
  assign ev.per_sec    = st.ctrl[`BPSL_B_SEC_PER];

  bpsl_classify u_cls (
    .ev (ev.cls)
  );

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  // setup captures read data, access phase completes with no wait
  assign setup  = PSEL && !PENABLE;
  assign wr_acc = PSEL && PENABLE && PWRITE;
  assign mapped = hit(PADDR, `BPSL_OFF_STATUS) || hit(PADDR, `BPSL_OFF_MASK) ||
                  hit(PADDR, `BPSL_OFF_CTRL);
  assign w1c    = (wr_acc && hit(PADDR, `BPSL_OFF_STATUS)) ? PWDATA[3:0] : 4'h0;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    // sticky bits, set wins over write-one clear
    next_st.status = (st.status & ~w1c) | ev.set;
    if (wr_acc && hit(PADDR, `BPSL_OFF_MASK)) begin
      next_st.mask = PWDATA[3:0];
    end
    if (wr_acc && hit(PADDR, `BPSL_OFF_CTRL)) begin
      next_st.ctrl = PWDATA[1:0];
    end
    if (setup) begin
      next_st.slverr = !mapped;
      next_st.rdata  = 32'h0;
      if (hit(PADDR, `BPSL_OFF_STATUS)) begin
        next_st.rdata = {28'h0, st.status};
      end else if (hit(PADDR, `BPSL_OFF_MASK)) begin
        next_st.rdata = {28'h0, st.mask};
      end else if (hit(PADDR, `BPSL_OFF_CTRL)) begin
        next_st.rdata = {30'h0, st.ctrl};
      end
    end
    if (!RST_N) begin
      next_st        = '0;
      next_st.status = `BPSL_RST_STATUS;
      next_st.mask   = `BPSL_RST_MASK;
      next_st.ctrl   = `BPSL_RST_CTRL;
    end
  end

  // register the whole state
  always_ff @(posedge CLK) begin
    st <= next_st;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign PRDATA  = st.rdata;
  assign PSLVERR = st.slverr && PSEL && PENABLE;
  assign PREADY  = 1'b1;
  assign STATUS  = st.status;
  assign IRQ     = |(st.status & st.mask);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  // flags that the checks below build on
  logic       pri_det_evt;
  logic       sec_det_evt;
  logic [3:0] clr_req;

  // primary own-detection event of a qualifying kind
  assign pri_det_evt = EVT_VALID && EVT_BAD_PARITY && EVT_BUS == `BPSL_BUS_PRI &&
    ((EVT_KIND == bpsl_pkg::BPSL_READ && EVT_DIR == `BPSL_DIR_UP) ||
     ((EVT_KIND == bpsl_pkg::BPSL_PW || EVT_KIND == bpsl_pkg::BPSL_DW) &&
      EVT_DIR == `BPSL_DIR_DOWN));
  // secondary own-detection event of a qualifying kind
  assign sec_det_evt = EVT_VALID && EVT_BAD_PARITY && EVT_BUS == `BPSL_BUS_SEC &&
    ((EVT_KIND == bpsl_pkg::BPSL_READ && EVT_DIR == `BPSL_DIR_DOWN) ||
     ((EVT_KIND == bpsl_pkg::BPSL_PW || EVT_KIND == bpsl_pkg::BPSL_DW) &&
      EVT_DIR == `BPSL_DIR_UP));
  // write-one clear request as seen on the bus pins
  assign clr_req = (PSEL && PENABLE && PWRITE && PADDR == ADDR_W'(`BPSL_OFF_STATUS)) ?
                   PWDATA[3:0] : 4'h0;

  // primary own-detection event as one sampled step
  sequence s_pri_det_evt;
    pri_det_evt;
  endsequence

  // secondary own-detection event as one sampled step
  sequence s_sec_det_evt;
    sec_det_evt;
  endsequence

  // primary detected bit follows its event
  AST_PRI_DET_SET: assert property (
    s_pri_det_evt |=> STATUS[`BPSL_B_PRI_DET])
    else $error("primary detected bit not set");

  // primary detected bit rises only from a qualifying event
  AST_PRI_DET_ONLY: assert property (
    $rose(STATUS[`BPSL_B_PRI_DET]) |-> $past(pri_det_evt))
    else $error("primary detected bit set without cause");

  // secondary detected bit follows its event
  AST_SEC_DET_SET: assert property (
    s_sec_det_evt |=> STATUS[`BPSL_B_SEC_DET])
    else $error("secondary detected bit not set");

  // secondary detected bit rises only from a qualifying event
  AST_SEC_DET_ONLY: assert property (
    $rose(STATUS[`BPSL_B_SEC_DET]) |-> $past(sec_det_evt))
    else $error("secondary detected bit set without cause");

  // primary data-parity bit needs mastership on primary
  AST_PRI_DPD_MASTER: assert property (
    $rose(STATUS[`BPSL_B_PRI_DPD]) |-> $past(PRI_MASTER))
    else $error("primary data parity set while not master");

  // primary data-parity bit needs its enable
  AST_PRI_DPD_EN: assert property (
    !st.ctrl[`BPSL_B_PRI_PER] && !STATUS[`BPSL_B_PRI_DPD] |=> !STATUS[`BPSL_B_PRI_DPD])
    else $error("primary data parity set with enable clear");

  // primary pin report on an upstream mastered transfer sets the bit
  AST_PRI_DPD_PIN: assert property (
    EVT_VALID && !PRIMARY_PARITY_ERR_N && EVT_BUS == `BPSL_BUS_PRI &&
    EVT_DIR == `BPSL_DIR_UP && EVT_KIND != 2'h2 && PRI_MASTER &&
    st.ctrl[`BPSL_B_PRI_PER] |=> STATUS[`BPSL_B_PRI_DPD])
    else $error("primary pin report lost");

  // primary data-parity bit only for upstream on primary
  AST_PRI_DPD_DIR: assert property (
    $rose(STATUS[`BPSL_B_PRI_DPD]) |->
      $past(EVT_DIR == `BPSL_DIR_UP && EVT_BUS == `BPSL_BUS_PRI))
    else $error("primary data parity set for wrong direction");

  // secondary data-parity bit needs mastership and enable
  AST_SEC_DPD_GATE: assert property (
    $rose(STATUS[`BPSL_B_SEC_DPD]) |->
      $past(SEC_MASTER && st.ctrl[`BPSL_B_SEC_PER]))
    else $error("secondary data parity set without gate");

  // secondary pin report on a downstream mastered transfer sets the bit
  AST_SEC_DPD_PIN: assert property (
    EVT_VALID && !SECONDARY_PARITY_ERR_N && EVT_BUS == `BPSL_BUS_SEC &&
    EVT_DIR == `BPSL_DIR_DOWN && EVT_KIND != 2'h2 && SEC_MASTER &&
    st.ctrl[`BPSL_B_SEC_PER] |=> STATUS[`BPSL_B_SEC_DPD])
    else $error("secondary pin report lost");

  // primary detected bit stays until a write-one clear
  AST_STICKY: assert property (
    STATUS[`BPSL_B_PRI_DET] && !clr_req[`BPSL_B_PRI_DET]
      |=> STATUS[`BPSL_B_PRI_DET])
    else $error("sticky bit dropped without clear");

  // interrupt tracks masked status
  AST_IRQ: assert property (
    $rose(|(STATUS & st.mask)) |-> IRQ ##1 (IRQ || $past(|w1c) || $changed(st.mask)))
    else $error("interrupt not following status");

  // secondary data-parity bit needs its enable
  AST_SEC_DPD_EN: assert property (
    !st.ctrl[`BPSL_B_SEC_PER] && !STATUS[`BPSL_B_SEC_DPD] |=> !STATUS[`BPSL_B_SEC_DPD])
    else $error("secondary data parity set with enable clear");

  // secondary data-parity bit only for downstream on secondary
  AST_SEC_DPD_DIR: assert property (
    $rose(STATUS[`BPSL_B_SEC_DPD]) |->
      $past(EVT_DIR == `BPSL_DIR_DOWN && EVT_BUS == `BPSL_BUS_SEC && EVT_KIND != 2'h2))
    else $error("secondary data parity set for wrong direction");

  // own bad parity on an upstream mastered transfer sets the primary bit
  AST_PRI_DPD_BAD: assert property (
    EVT_VALID && EVT_BAD_PARITY && EVT_BUS == `BPSL_BUS_PRI &&
    EVT_DIR == `BPSL_DIR_UP && EVT_KIND != 2'h2 && PRI_MASTER &&
    st.ctrl[`BPSL_B_PRI_PER] |=> STATUS[`BPSL_B_PRI_DPD])
    else $error("primary bad parity lost");

  // own bad parity on a downstream mastered transfer sets the secondary bit
  AST_SEC_DPD_BAD: assert property (
    EVT_VALID && EVT_BAD_PARITY && EVT_BUS == `BPSL_BUS_SEC &&
    EVT_DIR == `BPSL_DIR_DOWN && EVT_KIND != 2'h2 && SEC_MASTER &&
    st.ctrl[`BPSL_B_SEC_PER] |=> STATUS[`BPSL_B_SEC_DPD])
    else $error("secondary bad parity lost");

  // no status bit drops unless cleared by a write of one
  AST_STICKY_ALL: assert property (
    |(STATUS & ~clr_req) |=>
      ((($past(STATUS) & ~$past(clr_req)) & ~STATUS) == 4'h0))
    else $error("status bit dropped without clear");

  // a set in the clearing cycle wins
  AST_SET_WINS: assert property (
    |ev.set |=>
      ((STATUS & $past(ev.set)) == $past(ev.set)))
    else $error("status set lost against clear");

  // reset clears status, interrupt and read data
  AST_RESET_CLEAR: assert property (
    disable iff (1'b0)
    !RST_N |=> STATUS == `BPSL_RST_STATUS && !IRQ && PRDATA == 32'h0)
    else $error("reset left state behind");

  // status read returns the bits standing at the setup edge
  AST_RDATA_STATUS: assert property (
    PSEL && !PENABLE && PADDR == ADDR_W'(`BPSL_OFF_STATUS) |=>
      PRDATA == {28'h0, $past(STATUS)})
    else $error("status read data wrong");

  // slave error exactly for an unmapped address
  AST_APB_SLVERR: assert property (
    PSEL && !PENABLE |=> (PSEL && PENABLE |->
      PSLVERR == !$past(PADDR == ADDR_W'(`BPSL_OFF_STATUS) ||
                        PADDR == ADDR_W'(`BPSL_OFF_MASK) || PADDR == ADDR_W'(`BPSL_OFF_CTRL))))
    else $error("slave error wrong");

  // every access phase completes at once
  AST_APB_READY: assert property (
    PSEL && PENABLE |-> PREADY)
    else $error("access not ready");

  // interrupt low while no unmasked bit is set
  AST_IRQ_LOW: assert property (
    !(|(STATUS & st.mask)) |-> !IRQ)
    else $error("interrupt without unmasked status");

  // mask write lands at the access edge
  AST_MASK_WRITE: assert property (
    PSEL && PENABLE && PWRITE && PADDR == ADDR_W'(`BPSL_OFF_MASK) |=>
      st.mask == $past(PWDATA[3:0]))
    else $error("mask write lost");

endmodule

// *** verification/bpsl_pci_peer.sv ***
// far-side targets that flag data parity errors on either bus
`timescale 1ns/1ps
`include "bpsl_defines.svh"
module bpsl_pci_peer (
  // request from the bench
  input  wire logic fire,
  input  wire logic bus,
  // error pins, pulled up while released
  output      logic pri_err_n,
  output      logic sec_err_n
);
  // a target pulls its pin low in the data cycle that it flags
  assign pri_err_n = !(fire && bus == `BPSL_BUS_PRI);
  assign sec_err_n = !(fire && bus == `BPSL_BUS_SEC);
endmodule

// *** verification/bridge_parity_status_logic_tb_top.sv ***
// self-checking bench of the bridge parity status logic
`timescale 1ns/1ps
`include "bpsl_defines.svh"
module bridge_parity_status_logic_tb_top;
  logic        clk = 1'h0, rst_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, irq, er, fire = 1'h0, pri_n, sec_n;
  logic        ev_valid = 1'h0, ev_dir = 1'h0, ev_bus = 1'h0, ev_bad = 1'h0;
  logic        pri_m = 1'h0, sec_m = 1'h0;
  logic [1:0]  ev_kind = 2'h0;
  logic [3:0]  status;
  int          mismatches = 0, num_checks = 0, cycles = 0;

  bpsl_top #(.ADDR_W(8)) u_dut (
    .CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .EVT_VALID(ev_valid), .EVT_KIND(ev_kind), .EVT_DIR(ev_dir), .EVT_BUS(ev_bus),
    .EVT_BAD_PARITY(ev_bad), .PRIMARY_PARITY_ERR_N(pri_n), .SECONDARY_PARITY_ERR_N(sec_n),
    .PRI_MASTER(pri_m), .SEC_MASTER(sec_m), .STATUS(status), .IRQ(irq));

  bpsl_pci_peer u_peer (.fire(fire), .bus(ev_bus), .pri_err_n(pri_n), .sec_err_n(sec_n));

  // clock and hang guard
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      finish_test();
    end
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer, read data and error land in rd and er
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do begin
      @(posedge clk);
    end while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  // one-cycle parity event, returns just after the sampling edge
  task automatic evt(input logic [1:0] k, input logic d, b, bad, pin);
    @(posedge clk);
    ev_valid <= 1'h1;
    ev_kind <= k;
    ev_dir <= d;
    ev_bus <= b;
    ev_bad <= bad;
    fire <= pin;
    @(posedge clk);
    ev_valid <= 1'h0;
    ev_bad <= 1'h0;
    fire <= 1'h0;
    #1;
  endtask

  // status bits that one event must set
  function automatic logic [3:0] exp_set(input logic [1:0] k, input logic d, b, bad, pin,
                                         input logic [1:0] en, input logic pm, sm);
    logic rdk;
    rdk = (k == bpsl_pkg::BPSL_READ);
    exp_set[0] = bad && b == `BPSL_BUS_PRI && (rdk ? d == `BPSL_DIR_UP : d == `BPSL_DIR_DOWN);
    exp_set[1] = bad && b == `BPSL_BUS_SEC && (rdk ? d == `BPSL_DIR_DOWN : d == `BPSL_DIR_UP);
    exp_set[2] = (bad || pin) && b == `BPSL_BUS_PRI && d == `BPSL_DIR_UP && pm && en[0];
    exp_set[3] = (bad || pin) && b == `BPSL_BUS_SEC && d == `BPSL_DIR_DOWN && sm && en[1];
  endfunction

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  // reset values, width of fields, unmapped place
  task automatic t_regs();
    apb(1'h0, `BPSL_OFF_STATUS, 32'h0);
    check(rd, 32'h0);
    check(er, 1'h0);
    check(pready, 1'h1);
    apb(1'h0, `BPSL_OFF_CTRL, 32'h0);
    check(rd, 32'h0);
    apb(1'h1, `BPSL_OFF_MASK, 32'hFFFFFFFF);
    apb(1'h0, `BPSL_OFF_MASK, 32'h0);
    check(rd, 32'hF);
    apb(1'h1, `BPSL_OFF_MASK, 32'h0);
    apb(1'h1, 8'h0C, 32'hF);
    check(er, 1'h1);
    apb(1'h0, 8'h0C, 32'h0);
    check({rd[30:0], er}, 32'h1);
  endtask

  // every kind, direction, bus, trigger, enable pair and master pair
  task automatic t_decode();
    bpsl_pkg::bpsl_kind_t kinds[3] = '{bpsl_pkg::BPSL_READ, bpsl_pkg::BPSL_PW, bpsl_pkg::BPSL_DW};
    logic [3:0] e;
    logic [1:0] en2;
    logic [1:0] m2;
    for (int en = 0; en < 4; en++) begin
      en2 = 2'(en);
      apb(1'h1, `BPSL_OFF_CTRL, 32'(en));
      for (int m = 0; m < 4; m++) begin
        m2 = 2'(m);
        @(posedge clk);
        pri_m <= m2[0];
        sec_m <= m2[1];
        for (int i = 0; i < 36; i++) begin
          evt(kinds[i%3], 1'((i/3)%2), 1'((i/6)%2), i/12 == 1, i/12 == 2);
          e = exp_set(kinds[i%3], 1'((i/3)%2), 1'((i/6)%2), i/12 == 1, i/12 == 2,
                      en2, m2[0], m2[1]);
          check(status[1:0], e[1:0]);
          check(status[2], e[2]);
          check(status[3], e[3]);
          check(irq, 1'h0);
          apb(1'h1, `BPSL_OFF_STATUS, 32'hF);
          #1 check(status, 4'h0);
        end
      end
    end
  endtask

  // sticky bit, mask, interrupt, write-one clear, illegal kind
  task automatic t_sticky();
    apb(1'h1, `BPSL_OFF_CTRL, 32'h0);
    evt(bpsl_pkg::BPSL_READ, `BPSL_DIR_UP, `BPSL_BUS_PRI, 1'h1, 1'h0);
    check(irq, 1'h0);
    apb(1'h1, `BPSL_OFF_MASK, 32'h1);
    #1 check(irq, 1'h1);
    apb(1'h1, `BPSL_OFF_STATUS, 32'hE);
    apb(1'h0, `BPSL_OFF_STATUS, 32'h0);
    check(rd, 32'h1);
    apb(1'h1, `BPSL_OFF_STATUS, 32'h1);
    #1 check(status, 4'h0);
    check(irq, 1'h0);
    evt(2'h2, `BPSL_DIR_DOWN, `BPSL_BUS_PRI, 1'h1, 1'h0);
    check(status, 4'h0);
    // event lands on the same edge as the write-one clear
    fork
      apb(1'h1, `BPSL_OFF_STATUS, 32'hF);
      begin
        @(posedge clk);
        evt(bpsl_pkg::BPSL_READ, `BPSL_DIR_UP, `BPSL_BUS_PRI, 1'h1, 1'h0);
      end
    join
    check(status, 4'h1);
    check(irq, 1'h1);
  endtask

  // a reset in mid-run clears bits, mask and interrupt
  task automatic t_reset();
    apb(1'h1, `BPSL_OFF_MASK, 32'h2);
    evt(bpsl_pkg::BPSL_PW, `BPSL_DIR_UP, `BPSL_BUS_SEC, 1'h1, 1'h0);
    check(status, 4'h3);
    check(irq, 1'h1);
    @(posedge clk);
    rst_n <= 1'h0;
    @(posedge clk);
    rst_n <= 1'h1;
    #1 check({irq, status}, 5'h0);
    apb(1'h0, `BPSL_OFF_MASK, 32'h0);
    check(rd, 32'h0);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // reset, then the scenarios in turn
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'h1;
    t_regs();
    t_decode();
    t_sticky();
    t_reset();
    finish_test();
  end
endmodule
